// ### core/hfadc_host.sv
// Purpose: host controller driving a half-flash 8-bit converter through its pins
// Assumes: all device pins synchronous to clk_i; AXI4-Lite slave for software
// Notes: one conversion at a time; result captured while read strobe is low

`timescale 1ns/1ps

module hfadc_host
   import hfadc_pkg::*;
#(
   parameter int CHAN_W = 3
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   input wire logic [3:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic wr_oe_o,
   input wire logic rdy_i,
   input wire logic conv_done_n_i,
   input wire logic [7:0] result_i,
   output logic sleep_n_o,
   output logic mode_o,
   output logic [CHAN_W-1:0] channel_select_o
);

   // ************************************
   // state
   // ************************************
   hfadc_state_type st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   hfadc_pins_type pins_reg, pins_next;
   hfadc_pins_type cfg_next;
   logic [7:0] data_reg, data_next;
   logic done_reg, done_next;
   logic awake_reg, awake_next;
   logic go_reg, go_next;
   logic aw_reg, aw_next;
   logic w_reg, w_next;
   logic [3:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic bv_reg, bv_next;
   logic [1:0] br_reg, br_next;
   logic rv_reg, rv_next;
   logic [31:0] rd_reg, rd_next;
   logic [1:0] rr_reg, rr_next;
   logic wr_do, done_set, cnt_zero;

   // ************************************
   // helpers
   // ************************************
   // load value for a down counter that runs c cycles
   function automatic logic [7:0] cyc8(input int c);
      return 8'(c - 1);
   endfunction : cyc8

   assign cnt_zero = (cnt_reg == 8'h00);
   assign wr_do = aw_reg && w_reg && !bv_reg;

   // ************************************
   // bus slave
   // ************************************
   always_comb begin
      aw_next = aw_reg;
      w_next = w_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      go_next = 1'b0;
      cfg_next = pins_reg;
      if (s_awvalid_i && !aw_reg) begin
         aw_next = 1'b1;
         awa_next = s_awaddr_i;
      end
      if (s_wvalid_i && !w_reg) begin
         w_next = 1'b1;
         wd_next = s_wdata_i;
      end
      if (wr_do) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         br_next = RESP_OKAY;
         if (awa_reg == CTRL_OFS) begin
            if (s_wstrb_i[0] || wd_reg[CTRL_START_BIT] || 1'b1) begin
               cfg_next.mode = wd_reg[CTRL_MODE_BIT];
               cfg_next.sleep_n = wd_reg[CTRL_SLEEP_BIT];
               cfg_next.chan = wd_reg[CTRL_CH_LSB +: 3];
               // start lasts one cycle; dropped unless awake and idle
               go_next = wd_reg[CTRL_START_BIT];
            end
         end else if (awa_reg != STAT_OFS && awa_reg != DATA_OFS) begin
            br_next = RESP_SLVERR;
         end
      end
      if (bv_reg && s_bready_i) begin
         bv_next = 1'b0;
      end
      if (s_arvalid_i && !rv_reg) begin
         rv_next = 1'b1;
         rr_next = RESP_OKAY;
         case (s_araddr_i)
            CTRL_OFS: rd_next = {25'h0, pins_reg.chan, 1'b0, pins_reg.sleep_n,
                                 pins_reg.mode, 1'b0};
            STAT_OFS: rd_next = {29'h0, awake_reg, done_reg, st_reg != ST_IDLE};
            DATA_OFS: rd_next = {24'h0, data_reg};
            default: begin
               rd_next = 32'h0;
               rr_next = RESP_SLVERR;
            end
         endcase
      end else if (rv_reg && s_rready_i) begin
         rv_next = 1'b0;
      end
   end

   // ************************************
   // conversion sequencer
   // ************************************
   always_comb begin
      pins_next = cfg_next;
      st_next = st_reg;
      cnt_next = cnt_zero ? 8'h00 : cnt_reg - 8'h01;
      data_next = data_reg;
      done_set = 1'b0;
      awake_next = awake_reg;
      if (!pins_next.sleep_n) begin
         awake_next = 1'b0;
      end
      case (st_reg)
         ST_IDLE: begin
            if (pins_next.sleep_n && !pins_reg.sleep_n) begin
               st_next = ST_WAKE;
               cnt_next = cyc8(WAKE_CYC);
            end else if (go_reg && pins_reg.sleep_n && awake_reg) begin
               st_next = ST_ACQ;
               cnt_next = cyc8(ACQ_CYC);
            end
         end
         ST_WAKE: begin
            if (cnt_zero) begin
               awake_next = 1'b1;
               st_next = ST_IDLE;
            end
         end
         ST_ACQ: begin
            if (cnt_zero) begin
               if (pins_reg.mode) begin
                  st_next = ST_WR_LOW;
                  cnt_next = cyc8(WR_PULSE_CYC);
               end else begin
                  st_next = ST_RD_CONV;
                  cnt_next = cyc8(CONV_RD_CYC + RDY_CYC);
               end
            end
         end
         ST_WR_LOW: begin
            if (cnt_zero) begin
               st_next = ST_WR_GAP;
               cnt_next = cyc8(WR_RD_GAP_CYC);
            end
         end
         ST_WR_GAP: begin
            if (cnt_zero && !conv_done_n_i) begin
               st_next = ST_RD_LOW;
               cnt_next = cyc8(ACCESS_CYC);
            end
         end
         ST_RD_CONV: begin
            if (cnt_zero && rdy_i && !conv_done_n_i) begin
               st_next = ST_RD_LOW;
               cnt_next = cyc8(ACCESS_CYC);
            end
         end
         ST_RD_LOW: begin
            if (cnt_zero) begin
               data_next = result_i;
               done_set = 1'b1;
               st_next = ST_RELEASE;
               cnt_next = cyc8(HOLD_CYC);
            end
         end
         ST_RELEASE: begin
            if (cnt_zero) begin
               st_next = ST_IDLE;
            end
         end
         default: st_next = ST_IDLE;
      endcase
      done_next = done_set ? 1'b1 : (go_reg ? 1'b0 : done_reg);
      // strobes decoded from the next state so they launch with it
      pins_next.cs_n = !(st_next inside {ST_WR_LOW, ST_WR_GAP, ST_RD_LOW, ST_RD_CONV});
      pins_next.rd_n = !(st_next inside {ST_RD_LOW, ST_RD_CONV});
      pins_next.wr_n = !(st_next == ST_WR_LOW);
      pins_next.wr_oe = pins_next.mode;
   end

   // ************************************
   // registers
   // ************************************
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         pins_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, wr_oe: 1'b0,
                       sleep_n: 1'b0, mode: 1'b0, chan: 3'h0};
         data_reg <= 8'h00;
         done_reg <= 1'b0;
         awake_reg <= 1'b0;
         go_reg <= 1'b0;
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awa_reg <= 4'h0;
         wd_reg <= 32'h0;
         bv_reg <= 1'b0;
         br_reg <= 2'h0;
         rv_reg <= 1'b0;
         rd_reg <= 32'h0;
         rr_reg <= 2'h0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         data_reg <= data_next;
         done_reg <= done_next;
         awake_reg <= awake_next;
         go_reg <= go_next;
         aw_reg <= aw_next;
         w_reg <= w_next;
         awa_reg <= awa_next;
         wd_reg <= wd_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign s_awready_o = !aw_reg;
   assign s_wready_o = !w_reg;
   assign s_bvalid_o = bv_reg;
   assign s_bresp_o = br_reg;
   assign s_arready_o = !rv_reg;
   assign s_rvalid_o = rv_reg;
   assign s_rdata_o = rd_reg;
   assign s_rresp_o = rr_reg;
   assign cs_n_o = pins_reg.cs_n;
   assign rd_n_o = pins_reg.rd_n;
   assign wr_n_o = pins_reg.wr_n;
   assign wr_oe_o = pins_reg.wr_oe;
   assign sleep_n_o = pins_reg.sleep_n;
   assign mode_o = pins_reg.mode;
   assign channel_select_o = pins_reg.chan[CHAN_W-1:0];

endmodule : hfadc_host

// ### core/hfadc_pkg.sv
// Purpose: constants and types for the half-flash converter host controller
// Assumes: 10 MHz system clock, AXI4-Lite register access
// Notes: times in ns, cycle counts derived with rounding up

package hfadc_pkg;

   // ************************************
   // clock and timing
   // ************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int WAKE_NS = 360;
   localparam int ACQ_NS = 260;
   localparam int WR_PULSE_NS = 400;
   localparam int WR_RD_GAP_NS = 450;
   localparam int ACCESS_NS = 275;
   localparam int RDY_NS = 100;
   localparam int CONV_RD_NS = 1050;
   localparam int HOLD_NS = 100;

   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc

   localparam int WAKE_CYC = ns2cyc(WAKE_NS);
   localparam int ACQ_CYC = ns2cyc(ACQ_NS);
   localparam int WR_PULSE_CYC = ns2cyc(WR_PULSE_NS);
   localparam int WR_RD_GAP_CYC = ns2cyc(WR_RD_GAP_NS);
   localparam int ACCESS_CYC = ns2cyc(ACCESS_NS);
   localparam int RDY_CYC = ns2cyc(RDY_NS);
   localparam int CONV_RD_CYC = ns2cyc(CONV_RD_NS);
   localparam int HOLD_CYC = ns2cyc(HOLD_NS);

   // ************************************
   // register map
   // ************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] DATA_OFS = 4'h8;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_SLEEP_BIT = 2;
   localparam int CTRL_CH_LSB = 4;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_AWAKE_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_WAKE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_WR_LOW = 4'b0011,
      ST_WR_GAP = 4'b0100,
      ST_RD_LOW = 4'b0101,
      ST_RD_CONV = 4'b0110,
      ST_RELEASE = 4'b0111
   } hfadc_state_type;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic wr_oe;
      logic sleep_n;
      logic mode;
      logic [2:0] chan;
   } hfadc_pins_type;

endpackage : hfadc_pkg

// ### sim/hfadc_dev_model.sv
// Purpose: behavioural converter on the far side of the host
// Assumes: pins sampled on the system clock
// Notes: conversion length set per test through conv_cyc_i
`timescale 1ns/1ps
module hfadc_dev_model (
   input wire logic clk_i,
   input wire logic [7:0] conv_cyc_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic sleep_n_i,
   input wire logic mode_i,
   input wire logic [2:0] chan_i,
   output logic rdy_low_o,
   output logic conv_done_n_o,
   output logic [7:0] result_o
);
   logic [7:0] cnt = 8'h0;
   logic busy = 1'h0;
   logic rd_q = 1'h1;
   logic wr_q = 1'h1;
   logic [7:0] val;
   initial conv_done_n_o = 1'h1;
   always @(posedge clk_i) begin
      rd_q <= rd_n_i;
      wr_q <= wr_n_i;
      if (!sleep_n_i) begin
         busy <= 1'h0;
         conv_done_n_o <= 1'h1;
      end else if (!cs_n_i && !mode_i && !rd_n_i && rd_q) begin
         busy <= 1'h1;
         cnt <= conv_cyc_i;
      end else if (!cs_n_i && mode_i && wr_n_i && !wr_q) begin
         busy <= 1'h1;
         cnt <= conv_cyc_i;
      end else if (busy && cnt != 8'h0) begin
         cnt <= cnt - 8'h1;
      end else if (busy) begin
         busy <= 1'h0;
         conv_done_n_o <= 1'h0;
      end
      if (rd_n_i && !rd_q) conv_done_n_o <= 1'h1;
   end
   assign rdy_low_o = !mode_i && !cs_n_i && conv_done_n_o;
   assign val = (chan_i == 3'h7) ? 8'hFF : {1'h0, chan_i, 4'h5};
   assign result_o = (!cs_n_i && !rd_n_i) ? val : ~val;
endmodule : hfadc_dev_model

// ### sim/hfadc_host_properties.sv
// Purpose: pin timing checks for the converter host
// Assumes: one clock, sync active low reset
// Notes: bound to hfadc_host from the bench top
`timescale 1ns/1ps
module hfadc_host_properties #(
   parameter int CHAN_W = 3
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic wr_oe_o,
   input wire logic sleep_n_o,
   input wire logic mode_o,
   input wire logic [CHAN_W-1:0] channel_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ****
   // pin rules
   // ****
   property p_reset_idle;
      disable iff (1'h0) !nrst_i |=> cs_n_o && rd_n_o && wr_n_o && !sleep_n_o && !wr_oe_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("strobe active in reset");
   property p_cs_guard;
      !rd_n_o || !wr_n_o |-> !cs_n_o;
   endproperty
   a_cs_guard: assert property (p_cs_guard) else $error("strobe without select");
   property p_oe_mode;
      !mode_o |-> !wr_oe_o;
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("ready pin driven");
   property p_wake_wait;
      $rose(sleep_n_o) |-> cs_n_o [*4];
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("start too soon");
   property p_acq_stable;
      $fell(cs_n_o) |-> $past(channel_select_o, 3) == channel_select_o;
   endproperty
   a_acq_stable: assert property (p_acq_stable) else $error("channel not settled");
   property p_chan_hold;
      !cs_n_o |-> $stable(channel_select_o);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
   property p_wr_pulse;
      $fell(wr_n_o) |-> !wr_n_o [*4] ##1 wr_n_o;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse width");
   property p_wr_rd_gap;
      $rose(wr_n_o) && !cs_n_o |-> rd_n_o [*5];
   endproperty
   a_wr_rd_gap: assert property (p_wr_rd_gap) else $error("write to read gap");
   property p_rd_min;
      $fell(rd_n_o) && !mode_o |-> !rd_n_o [*8];
   endproperty
   a_rd_min: assert property (p_rd_min) else $error("read strobe short");
   c_rd: cover property ($fell(rd_n_o) && !mode_o);
   c_wr: cover property ($fell(wr_n_o));
   c_wake: cover property ($rose(sleep_n_o));
endmodule : hfadc_host_properties

// ### sim/hfadc_host_tb.sv
// Purpose: self-checking bench for hfadc_host
// Assumes: AXI4-Lite master tasks, device model at the pins
// Notes: row table for conversions, hand tests after
`timescale 1ns/1ps
module hfadc_host_tb import hfadc_pkg::*;;
   typedef struct packed {logic [2:0] ch; logic md; logic [7:0] cyc; logic [7:0] ex;} hfadc_row_type;
   hfadc_row_type rows [8] = '{'{3'h0, 1'h0, 8'h04, 8'h05}, '{3'h1, 1'h1, 8'h04, 8'h15},
      '{3'h2, 1'h0, 8'h1E, 8'h25}, '{3'h3, 1'h1, 8'h1E, 8'h35}, '{3'h4, 1'h0, 8'h04, 8'h45},
      '{3'h5, 1'h1, 8'h04, 8'h55}, '{3'h6, 1'h0, 8'h1E, 8'h65}, '{3'h7, 1'h1, 8'h1E, 8'hFF}};
   logic clk_i = 1'h0, nrst_i = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [1:0] bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid, rdy, done_n, rdy_low;
   logic cs_n, rd_n, wr_n, wr_oe, sleep_n, mode;
   logic [2:0] chan;
   logic [7:0] result, conv_cyc = 8'h04;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   assign rdy = wr_oe ? wr_n : !rdy_low;
   hfadc_host uut (.clk_i(clk_i), .nrst_i(nrst_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
      .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid),
      .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
      .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata),
      .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .wr_oe_o(wr_oe), .rdy_i(rdy), .conv_done_n_i(done_n),
      .result_i(result), .sleep_n_o(sleep_n), .mode_o(mode), .channel_select_o(chan));
   hfadc_dev_model dev (.clk_i(clk_i), .conv_cyc_i(conv_cyc), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .sleep_n_i(sleep_n), .mode_i(mode), .chan_i(chan),
      .rdy_low_o(rdy_low), .conv_done_n_o(done_n), .result_o(result));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task conclude;
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      rsp = bresp;
      bready <= 1'h0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      got = rdata;
      rsp = rresp;
      rready <= 1'h0;
   endtask : rd
   task wait_flag(input int b);
      do rd(STAT_OFS); while (got[b] !== 1'h1);
   endtask : wait_flag
   initial begin
      repeat (6) @(posedge clk_i);
      chk({26'h0, cs_n, rd_n, wr_n, wr_oe, sleep_n, mode}, 32'h38);
      nrst_i <= 1'h1;
      rd(STAT_OFS);
      chk(got, 32'h0);
      wr(CTRL_OFS, 32'h75);
      rd(STAT_OFS);
      chk(got & 32'h4, 32'h0);
      wait_flag(STAT_AWAKE_BIT);
      chk(got, 32'h4);
      for (int i = 0; i < 8; i++) begin
         conv_cyc <= rows[i].cyc;
         wr(CTRL_OFS, {25'h0, rows[i].ch, 2'h1, rows[i].md, 1'h1});
         wait_flag(STAT_DONE_BIT);
         rd(DATA_OFS);
         chk(got, {24'h0, rows[i].ex});
      end
      rd(CTRL_OFS);
      chk(got, 32'h76);
      chk({27'h0, chan, wr_oe, mode}, 32'h1F);
      rd(4'hC);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(STAT_OFS, 32'hFFFFFFFF);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      wr(CTRL_OFS, 32'h1);
      rd(STAT_OFS);
      chk({got[2:0] & 3'h5, sleep_n, cs_n}, 5'h1);
      wr(CTRL_OFS, 32'h4);
      wait_flag(STAT_AWAKE_BIT);
      wr(CTRL_OFS, 32'h27);
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      chk({26'h0, cs_n, rd_n, wr_n, wr_oe, sleep_n, mode}, 32'h38);
      nrst_i <= 1'h1;
      rd(STAT_OFS);
      chk(got, 32'h0);
      conclude();
   end
endmodule : hfadc_host_tb
bind hfadc_host hfadc_host_properties #(.CHAN_W(CHAN_W)) props (.clk_i(clk_i),
   .nrst_i(nrst_i), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .wr_oe_o(wr_oe_o),
   .sleep_n_o(sleep_n_o), .mode_o(mode_o), .channel_select_o(channel_select_o));
